// ===== verilog/bmi_cfg_defs.vh
// bmi_cfg_defs.vh: offsets, field positions, reset values and timing
// counts for the bus-master interface configuration block.
// assumes: included by bare name; definitions only.
`ifndef BMI_CFG_DEFS_VH
`define BMI_CFG_DEFS_VH

// ============================================================
// register pointer values (pointer field bits 3:1)
`define PTR_INIT_ADDR_LOW   3'h3
`define PTR_BUS_MASTER_CFG  3'h4
`define PTR_INT_STATUS      3'h5
`define PTR_INT_MASK        3'h6
`define PTR_WM_STATUS       3'h7

// ============================================================
// bus_master_configuration fields
`define F_TX_WD_HI     15
`define F_TX_WD_LO     14
`define F_RX_WD_HI     13
`define F_RX_WD_LO     12
`define F_RX_ODD_ALIGN 11
`define F_TX_HOLDOFF   10
`define F_FWM_HI       9
`define F_FWM_LO       8
`define F_UPPER_ADDR   7
`define F_RELEASE_PIN  6
`define F_CTRL_SWAP    5
`define F_PIN_ALT      0

// ============================================================
// reset values
`define RST_INIT_ADDR_LOW 16'h0000
`define RST_BUS_CFG       16'h0000
`define RST_INT_MASK      16'h0000

// ============================================================
// interrupt status bits
`define IRQ_TX_WD   0
`define IRQ_RX_WD   1

// ============================================================
// watchdog timeouts, in system clocks (2^18, 2^19, 2^20)
`define WD_EXP_1    18
`define WD_EXP_2    19
`define WD_EXP_3    20
`define WD_CNT_W    21

// ============================================================
// fifo watermark word counts (receive / transmit fetch, hold-off)
`define FWM_N_11    6'h09
`define FWM_N_10    6'h11
`define FWM_N_01    6'h19
`define HOLD_N_11   6'h13
`define HOLD_N_10   6'h0b
`define HOLD_N_01   6'h03
`define FIFO_DEPTH  6'h20

// ============================================================
// provider primitive reported on watchdog expiry
`define PRIM_WATCHDOG 4'h3

`endif

// ===== verilog/clk_watchdog.v
// clk_watchdog.v: one serial-clock watchdog counter.
// assumes: serial clock pin already synchronised; restart is a pulse
// on any pin transition; runs on the system clock.
`include "bmi_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module clk_watchdog (
	// clock and reset
	input  wire       clock_i,
	input  wire       rst_n_i,
	// control
	input  wire [1:0] sel_i,     // 00 off, 01/10/11 timeout size
	input  wire       restart_i, // pin transition seen
	// result
	output reg        expire_o   // one-cycle pulse at timeout
);

	reg [`WD_CNT_W-1:0] cnt_q;  // cycles since last transition
	reg [`WD_CNT_W-1:0] limit;  // terminal count for selection

	// ============================================================
	// timeout decode
	always @* begin
		case (sel_i)
			2'h1:    limit = (21'h1 << `WD_EXP_1) - 21'h1;
			2'h2:    limit = (21'h1 << `WD_EXP_2) - 21'h1;
			2'h3:    limit = (21'h1 << `WD_EXP_3) - 21'h1;
			default: limit = 21'h0;
		endcase
	end

	// ============================================================
	// counter; holds at zero while disabled, rearms after expiry
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q    <= 21'h0;
			expire_o <= 1'b0;
		end else if (sel_i == 2'h0 || restart_i) begin
			cnt_q    <= 21'h0;
			expire_o <= 1'b0;
		end else if (cnt_q == limit) begin
			// a dead clock reports once per timeout period
			cnt_q    <= 21'h0;
			expire_o <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 21'h1;
			expire_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/pin_sync.v
// pin_sync.v: three-stage synchroniser with change detect.
// assumes: pin is asynchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	// clock and reset
	input  wire clock_i,
	input  wire rst_n_i,
	// pin
	input  wire pin_i,
	// results
	output wire level_o,  // agreed level
	output wire edge_o    // pulse on any transition
);

	reg s1_q;  // metastable stage, read by s2 only
	reg s2_q;
	reg s3_q;

	// ============================================================
	// chain; a change is flagged while stages two and three differ
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign level_o = s3_q;
	assign edge_o  = s2_q ^ s3_q;

endmodule
`default_nettype wire

// ===== verilog/bus_master_interface_config.v
// bus_master_interface_config.v: configuration registers of the
// bus-master interface, serial clock watchdogs, fifo watermark
// decisions, address line and shared pin steering, byte ordering.
// assumes: host port on the system clock; fifo levels and frame flags
// come from same-clock logic; serial clock pins are asynchronous.
`include "bmi_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bus_master_interface_config (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_n_i,
	// host register port
	input  wire [3:0]  addr_i,        // bits 3:1 are the pointer
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	// interrupt
	output wire        irq_o,
	// serial clock pins
	input  wire        tx_serial_clock_i,
	input  wire        rx_serial_clock_i,
	// provider primitive report
	output reg         prim_valid_o,  // one-cycle pulse
	output reg  [3:0]  prim_code_o,
	// receive fifo side
	input  wire [5:0]  rx_fifo_words_i,
	input  wire        rx_eof_in_fifo_i,
	output wire        rx_dma_req_o,
	// transmit fifo side
	input  wire [5:0]  tx_fifo_words_i,
	input  wire        tx_frame_complete_i,
	output wire        tx_dma_req_o,
	output wire        tx_start_ok_o,
	// receive byte alignment
	input  wire        rx_first_byte_i,
	input  wire [7:0]  rx_byte_i,
	output reg  [15:0] rx_word_o,
	output reg  [1:0]  rx_lane_we_o,
	// address lines
	input  wire [3:0]  dma_addr_19_16_i,
	input  wire [3:0]  bank_select_i,
	output reg  [3:0]  addr_23_20_o,
	// shared pin
	input  wire        shared_pin_i,
	output wire        bus_release_input_o,
	output wire        pin_alt_select_o,
	output wire        release_mode_o,
	// byte ordering
	input  wire        dma_is_data_i,
	input  wire [15:0] dma_word_i,
	output reg  [15:0] dma_word_o,
	// init block address
	output wire [15:0] init_block_address_o
);

	// ============================================================
	// registers
	reg  [15:0] init_block_address_low_q;  // low init address
	reg  [15:0] bus_master_configuration_q;
	reg  [1:0]  int_status_q;              // sticky watchdog events
	reg  [1:0]  int_mask_q;                // one enables
	reg  [1:0]  int_status_d;
	wire [2:0]  register_pointer;          // address bits 3:1
	wire        tx_expire;
	wire        rx_expire;
	wire        tx_edge;
	wire        rx_edge;
	wire        release_level;
	wire [1:0]  fifo_watermark;
	wire [5:0]  fetch_n;
	wire [5:0]  hold_n;

	assign register_pointer = addr_i[3:1];
	assign fifo_watermark   = bus_master_configuration_q[`F_FWM_HI:`F_FWM_LO];

	// ============================================================
	// decode helpers
	function [5:0] fwm_words;  // receive / transmit fetch words
		input [1:0] code;
		begin
			case (code)
				2'h3:    fwm_words = `FWM_N_11;
				2'h2:    fwm_words = `FWM_N_10;
				2'h1:    fwm_words = `FWM_N_01;
				// code 00 unspecified; treat as suggested setting
				default: fwm_words = `FWM_N_10;
			endcase
		end
	endfunction

	function [5:0] holdoff_words;
		input [1:0] code;
		begin
			case (code)
				2'h3:    holdoff_words = `HOLD_N_11;
				2'h2:    holdoff_words = `HOLD_N_10;
				2'h1:    holdoff_words = `HOLD_N_01;
				default: holdoff_words = `HOLD_N_10;
			endcase
		end
	endfunction

	assign fetch_n = fwm_words(fifo_watermark);
	assign hold_n  = holdoff_words(fifo_watermark);

	// ============================================================
	// register writes
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_block_address_low_q   <= `RST_INIT_ADDR_LOW;
			bus_master_configuration_q <= `RST_BUS_CFG;
			int_mask_q                 <= 2'h0;
		end else if (wr_i) begin
			case (register_pointer)
				`PTR_INIT_ADDR_LOW:
					init_block_address_low_q <= wdata_i;
				`PTR_BUS_MASTER_CFG:
					bus_master_configuration_q <= wdata_i;
				`PTR_INT_MASK:
					int_mask_q <= wdata_i[1:0];
				default: ;  // other pointers ignored
			endcase
		end
	end

	// ============================================================
	// sticky status; a new event wins over a write-one clear
	always @* begin
		int_status_d = int_status_q;
		if (wr_i && register_pointer == `PTR_INT_STATUS)
			int_status_d = int_status_d & ~wdata_i[1:0];
		if (tx_expire)
			int_status_d[`IRQ_TX_WD] = 1'b1;
		if (rx_expire)
			int_status_d[`IRQ_RX_WD] = 1'b1;
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			int_status_q <= 2'h0;
		else
			int_status_q <= int_status_d;
	end

	assign irq_o = |(int_status_q & int_mask_q);

	// ============================================================
	// read port; unmapped pointers read zero
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (register_pointer)
				`PTR_INIT_ADDR_LOW:  rdata_o <= init_block_address_low_q;
				`PTR_BUS_MASTER_CFG: rdata_o <= bus_master_configuration_q;
				`PTR_INT_STATUS:     rdata_o <= {14'h0, int_status_q};
				`PTR_INT_MASK:       rdata_o <= {14'h0, int_mask_q};
				`PTR_WM_STATUS:
					rdata_o <= {13'h0, tx_start_ok_o, tx_dma_req_o,
						rx_dma_req_o};
				default:             rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// the init block must start even; bit 0 is passed as written
	assign init_block_address_o = init_block_address_low_q;

	// ============================================================
	// serial clock synchronisers and watchdogs
	pin_sync u_tx_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (tx_serial_clock_i),
		.level_o (),
		.edge_o  (tx_edge)
	);

	pin_sync u_rx_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (rx_serial_clock_i),
		.level_o (),
		.edge_o  (rx_edge)
	);

	pin_sync u_rel_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (shared_pin_i),
		.level_o (release_level),
		.edge_o  ()
	);

	clk_watchdog u_tx_wd (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.sel_i     (bus_master_configuration_q[`F_TX_WD_HI:`F_TX_WD_LO]),
		.restart_i (tx_edge),
		.expire_o  (tx_expire)
	);

	clk_watchdog u_rx_wd (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.sel_i     (bus_master_configuration_q[`F_RX_WD_HI:`F_RX_WD_LO]),
		.restart_i (rx_edge),
		.expire_o  (rx_expire)
	);

	// ============================================================
	// provider primitive on any watchdog expiry
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prim_valid_o <= 1'b0;
			prim_code_o  <= 4'h0;
		end else begin
			prim_valid_o <= tx_expire | rx_expire;
			prim_code_o  <= (tx_expire | rx_expire) ?
				`PRIM_WATCHDOG : 4'h0;
		end
	end

	// ============================================================
	// fifo watermark decisions, combinational handshakes
	assign rx_dma_req_o = (rx_fifo_words_i >= fetch_n) |
		rx_eof_in_fifo_i;
	assign tx_dma_req_o =
		((`FIFO_DEPTH - tx_fifo_words_i) >= fetch_n);
	assign tx_start_ok_o = ~bus_master_configuration_q[`F_TX_HOLDOFF] |
		(tx_fifo_words_i >= hold_n) | tx_frame_complete_i;

	// ============================================================
	// receive alignment: first byte lands in both lanes
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_word_o    <= 16'h0000;
			rx_lane_we_o <= 2'h0;
		end else if (rx_first_byte_i &&
			bus_master_configuration_q[`F_RX_ODD_ALIGN]) begin
			rx_word_o    <= {rx_byte_i, rx_byte_i};
			rx_lane_we_o <= 2'h3;
		end else begin
			rx_word_o    <= {rx_byte_i, rx_byte_i};
			rx_lane_we_o <= 2'h0;
		end
	end

	// ============================================================
	// upper address lines: bank select or mirror of 19:16
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			addr_23_20_o <= 4'h0;
		else if (bus_master_configuration_q[`F_UPPER_ADDR])
			addr_23_20_o <= bank_select_i;
		else
			addr_23_20_o <= dma_addr_19_16_i;
	end

	// ============================================================
	// shared pin function
	assign release_mode_o = bus_master_configuration_q[`F_RELEASE_PIN];
	assign bus_release_input_o = release_mode_o & release_level;
	assign pin_alt_select_o = bus_master_configuration_q[`F_PIN_ALT];

	// ============================================================
	// byte ordering for non-data transfers only
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			dma_word_o <= 16'h0000;
		else if (!dma_is_data_i &&
			bus_master_configuration_q[`F_CTRL_SWAP])
			dma_word_o <= {dma_word_i[7:0], dma_word_i[15:8]};
		else
			dma_word_o <= dma_word_i;
	end

endmodule
`default_nettype wire

// ===== tb/bmi_cfg_properties.sv
// bmi_cfg_properties.sv: port checks of the configuration block.
// assumes: bound to bus_master_interface_config; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module bmi_cfg_properties (
	// clock and reset
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	// host port
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	// primitive report
	input wire logic        prim_valid_o,
	input wire logic [3:0]  prim_code_o,
	// fifo side
	input wire logic [5:0]  rx_fifo_words_i,
	input wire logic        rx_eof_in_fifo_i,
	input wire logic        rx_dma_req_o,
	input wire logic [5:0]  tx_fifo_words_i,
	input wire logic        tx_frame_complete_i,
	input wire logic        tx_dma_req_o,
	input wire logic        tx_start_ok_o,
	// address lines and shared pin
	input wire logic [3:0]  dma_addr_19_16_i,
	input wire logic [3:0]  bank_select_i,
	input wire logic [3:0]  addr_23_20_o,
	input wire logic        release_mode_o,
	input wire logic        pin_alt_select_o
);
	// ==========================================================
	// shadow of the configuration register
	logic [15:0] cfg_q; // follows host writes to pointer four

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// shadow copy, so the checks need no view inside the block
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i)
			cfg_q <= 16'h0000;
		else if (wr_i && addr_i[3:1] == 3'h4)
			cfg_q <= wdata_i;

	// watermark word counts per code; code 00 reads as 10
	function automatic int fetch_n(input logic [1:0] c);
		return (c == 2'h3) ? 9 : (c == 2'h1) ? 25 : 17;
	endfunction
	function automatic int hold_n(input logic [1:0] c);
		return (c == 2'h3) ? 19 : (c == 2'h1) ? 3 : 11;
	endfunction

	// ==========================================================
	// assertions
	a_unmapped_read: assert property (
		rd_i && addr_i[3:1] < 3'h3 |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_idle: assert property (
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data without a read");
	a_prim_code: assert property (
		prim_valid_o |-> prim_code_o == 4'h3)
		else $error("wrong primitive code on expiry");
	a_watchdog_off: assert property (
		cfg_q[15:12] == 4'h0 && $past(cfg_q[15:12]) == 4'h0
		|-> !prim_valid_o)
		else $error("expiry with watchdogs off");
	a_rx_fetch: assert property (
		rx_dma_req_o == (rx_eof_in_fifo_i
		|| rx_fifo_words_i >= fetch_n(cfg_q[9:8])))
		else $error("receive dma request wrong");
	a_tx_fetch: assert property (
		tx_dma_req_o == (tx_fifo_words_i + fetch_n(cfg_q[9:8]) <= 32))
		else $error("transmit fetch request wrong");
	a_tx_holdoff: assert property (
		tx_start_ok_o == (!cfg_q[10] || tx_frame_complete_i
		|| tx_fifo_words_i >= hold_n(cfg_q[9:8])))
		else $error("transmit hold-off wrong");
	a_upper_addr: assert property (
		1'b1 |=> addr_23_20_o == ($past(cfg_q[7]) ?
		$past(bank_select_i) : $past(dma_addr_19_16_i)))
		else $error("upper address lines wrong");
	a_pin_modes: assert property (
		release_mode_o == cfg_q[6] && pin_alt_select_o == cfg_q[0])
		else $error("shared pin mode bits wrong");

	// ==========================================================
	// covers
	c_rx_watermark: cover property (rx_dma_req_o && !rx_eof_in_fifo_i);
	c_tx_held: cover property (cfg_q[10] && !tx_start_ok_o);
	c_write_read: cover property (wr_i ##2 rd_i);
endmodule

bind bus_master_interface_config bmi_cfg_properties u_props (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.prim_valid_o(prim_valid_o), .prim_code_o(prim_code_o),
	.rx_fifo_words_i(rx_fifo_words_i),
	.rx_eof_in_fifo_i(rx_eof_in_fifo_i), .rx_dma_req_o(rx_dma_req_o),
	.tx_fifo_words_i(tx_fifo_words_i),
	.tx_frame_complete_i(tx_frame_complete_i),
	.tx_dma_req_o(tx_dma_req_o), .tx_start_ok_o(tx_start_ok_o),
	.dma_addr_19_16_i(dma_addr_19_16_i), .bank_select_i(bank_select_i),
	.addr_23_20_o(addr_23_20_o), .release_mode_o(release_mode_o),
	.pin_alt_select_o(pin_alt_select_o));
`default_nettype wire

// ===== tb/serial_clk_src.sv
// serial_clk_src.sv: far-side serial clock source for one pin.
// assumes: stands still while run_i is low, as between frames.
`timescale 1ns/1ps
`default_nettype none

module serial_clk_src #(parameter int HALF = 3) (
	input  wire logic clock_i, // system clock, paces the toggles
	input  wire logic run_i,   // link clock active
	output var  logic pin_o    // serial clock pin
);
	int cnt = 0; // cycles since last toggle
	initial pin_o = 1'b0;
	// each toggle is a transition that restarts the watchdog
	always @(posedge clock_i) begin
		if (run_i && ++cnt >= HALF) begin
			cnt = 0;
			pin_o <= ~pin_o;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_bus_master_interface_config.sv
// tb_bus_master_interface_config.sv: self-checking bench.
// assumes: checker is bound in; register model kept in an array.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_bus_master_interface_config;
	// ==========================================================
	// stimulus and observed signals
	logic clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0, dma_addr_19_16_i = 4'h0, bank_select_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000, dma_word_i = 16'h0000, d, w;
	logic [5:0] rx_fifo_words_i = 6'h00, tx_fifo_words_i = 6'h00;
	logic rx_eof_in_fifo_i = 1'b0, tx_frame_complete_i = 1'b0;
	logic rx_first_byte_i = 1'b0, shared_pin_i = 1'b0, dma_is_data_i = 1'b0;
	logic [7:0] rx_byte_i = 8'h00;
	logic run = 1'b0, tx_pin, rx_pin; // link clocks held still at first
	wire logic [15:0] rdata_o, rx_word_o, dma_word_o, init_block_address_o;
	wire logic [3:0] prim_code_o, addr_23_20_o;
	wire logic [1:0] rx_lane_we_o;
	wire logic irq_o, prim_valid_o, rx_dma_req_o, tx_dma_req_o;
	wire logic tx_start_ok_o, bus_release_input_o, pin_alt_select_o;
	wire logic release_mode_o;
	logic [15:0] m [8] = '{default: 16'h0000}; // register model
	int n_fail = 0, comparisons = 0, n_prim = 0;

	always #2.5 clock_i = ~clock_i;

	serial_clk_src #(.HALF(3)) u_tx_clk (.clock_i(clock_i), .run_i(run),
		.pin_o(tx_pin));
	serial_clk_src #(.HALF(7)) u_rx_clk (.clock_i(clock_i), .run_i(run),
		.pin_o(rx_pin));

	bus_master_interface_config u_dut (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.tx_serial_clock_i(tx_pin), .rx_serial_clock_i(rx_pin),
		.prim_valid_o(prim_valid_o), .prim_code_o(prim_code_o),
		.rx_fifo_words_i(rx_fifo_words_i),
		.rx_eof_in_fifo_i(rx_eof_in_fifo_i), .rx_dma_req_o(rx_dma_req_o),
		.tx_fifo_words_i(tx_fifo_words_i),
		.tx_frame_complete_i(tx_frame_complete_i),
		.tx_dma_req_o(tx_dma_req_o), .tx_start_ok_o(tx_start_ok_o),
		.rx_first_byte_i(rx_first_byte_i), .rx_byte_i(rx_byte_i),
		.rx_word_o(rx_word_o), .rx_lane_we_o(rx_lane_we_o),
		.dma_addr_19_16_i(dma_addr_19_16_i), .bank_select_i(bank_select_i),
		.addr_23_20_o(addr_23_20_o), .shared_pin_i(shared_pin_i),
		.bus_release_input_o(bus_release_input_o),
		.pin_alt_select_o(pin_alt_select_o),
		.release_mode_o(release_mode_o), .dma_is_data_i(dma_is_data_i),
		.dma_word_i(dma_word_i), .dma_word_o(dma_word_o),
		.init_block_address_o(init_block_address_o));

	// expiry cannot be reached in this run; any pulse, or an unknown
	// after reset, is counted
	always @(posedge clock_i) begin
		if (rst_n_i && prim_valid_o !== 1'b0)
			n_prim++;
	end

	// ==========================================================
	// model helpers and bus tasks
	function automatic int fetch_n(input logic [1:0] c);
		return (c == 2'h3) ? 9 : (c == 2'h1) ? 25 : 17;
	endfunction
	function automatic int hold_n(input logic [1:0] c);
		return (c == 2'h3) ? 19 : (c == 2'h1) ? 3 : 11;
	endfunction
	// read-only flags word, from the inputs and the model
	function automatic logic [15:0] flags();
		logic [1:0] f;
		f = m[4][9:8];
		return {13'h0000, !m[4][10] || tx_frame_complete_i
			|| tx_fifo_words_i >= hold_n(f),
			32 - tx_fifo_words_i >= fetch_n(f),
			rx_eof_in_fifo_i || rx_fifo_words_i >= fetch_n(f)};
	endfunction
	task automatic wr(input logic [2:0] p, input logic [15:0] v);
		@(posedge clock_i);
		addr_i <= {p, 1'b0};
		wdata_i <= v;
		wr_i <= 1'b1;
		// the mask keeps only its two event bits
		if (p == 3'h3 || p == 3'h4 || p == 3'h6)
			m[p] = (p == 3'h6) ? (v & 16'h0003) : v;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] p, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= {p, 1'b0};
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		`CHK("rdata", e, rdata_o)
	endtask
	task automatic finish_test();
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, well beyond the roughly six hundred cycles needed
	initial begin
		#50us;
		n_fail++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		d = 16'($urandom(32'h200c));
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		run <= 1'b1;
		for (int p = 0; p < 7; p++)
			rd(3'(p), 16'h0000);
		// registers, mask, clear-on-one status, unmapped place
		for (int i = 0; i < 6; i++) begin
			d = 16'($urandom);
			wr(3'h3, d & 16'hfffe);
			wr(3'h6, d ^ 16'h5a5a);
			wr(3'h5, 16'hffff);
			wr(3'h2, d);
			rd(3'h3, m[3]);
			rd(3'h6, m[6]);
			rd(3'h2, 16'h0000);
			rd(3'h5, 16'h0000);
			`CHK("init addr", m[3], init_block_address_o)
			`CHK("irq", 1'b0, irq_o)
		end
		// every watermark code, hold-off on and off, all levels
		for (int c = 0; c < 8; c++) begin
			wr(3'h4, (16'($urandom) & 16'hf8ff) | (16'(c) << 8));
			wr(3'h7, 16'hffff);
			rd(3'h4, m[4]);
			for (int j = 0; j <= 32; j++) begin
				@(posedge clock_i);
				rx_fifo_words_i <= 6'(j);
				tx_fifo_words_i <= 6'(32 - j);
				rx_eof_in_fifo_i <= 1'($urandom);
				tx_frame_complete_i <= 1'($urandom);
				@(negedge clock_i);
				w = {13'h0000, tx_start_ok_o, tx_dma_req_o, rx_dma_req_o};
				`CHK("flags", flags(), w)
			end
			rd(3'h7, flags());
		end
		// address lines, byte order, odd alignment, shared pin
		for (int i = 0; i < 16; i++) begin
			d = 16'($urandom);
			wr(3'h4, d);
			@(posedge clock_i);
			dma_addr_19_16_i <= d[3:0];
			bank_select_i <= d[7:4];
			dma_word_i <= ~d;
			dma_is_data_i <= d[1];
			rx_first_byte_i <= 1'b1;
			rx_byte_i <= d[15:8];
			shared_pin_i <= d[2];
			@(posedge clock_i);
			rx_first_byte_i <= 1'b0;
			@(negedge clock_i);
			w = ~d;
			if (m[4][5] && !d[1])
				w = {w[7:0], w[15:8]}; // non-data words only
			`CHK("addr hi", m[4][7] ? d[7:4] : d[3:0], addr_23_20_o)
			`CHK("dma word", w, dma_word_o)
			`CHK("rx lanes", m[4][11] ? 2'h3 : 2'h0, rx_lane_we_o)
			if (m[4][11])
				`CHK("rx word", {2{d[15:8]}}, rx_word_o)
			`CHK("pin mode", m[4][6], release_mode_o)
			`CHK("pin alt", m[4][0], pin_alt_select_o)
			repeat (4) @(negedge clock_i);
			// the pin reads low whenever the release mode is off
			`CHK("release in", m[4][6] & d[2], bus_release_input_o)
		end
		`CHK("expiries", 0, n_prim)
		finish_test();
	end
endmodule
`default_nettype wire
